// ---- hw/vhz_pkg.sv ----
// Operation
// - Each switch output has fixed period and amplitude, one pulse per period.
// - Symmetric mode centres every pulse on the middle of its period.
// - Edge-aligned mode starts every pulse at the start of its period.
// - Each lower switch output is always the complement of its upper output.
// - The three upper bits alone define the eight inverter states.
// - Command voltage follows command frequency at the rated volts-per-hertz ratio.
// - Above rated frequency profile one sets the command voltage to rated voltage; profile two only caps it at rated voltage, at any frequency.
// - At low frequency the voltage is boosted above the proportional value; only profile two boosts, profile one stays proportional.
// - Profile one never lets the command frequency drop below the floor frequency.
// - Profile one uses rated, floor and max frequency; rated voltage at rated frequency.
// - Profile two holds floor voltage when frequency falls below floor frequency.
// - Open loop takes supply frequency straight from the set speed, no slip correction.
// - Closed loop regulates slip with a PI controller on the speed error.
package vhz_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWM_PERIOD_NS = 50000;
  localparam int PWM_HALF_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS / 2;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_SPEED_SET = 8'h08;
  localparam logic [7:0] A_RATED_FREQ = 8'h0c;
  localparam logic [7:0] A_FLOOR_FREQ = 8'h10;
  localparam logic [7:0] A_MAX_FREQ = 8'h14;
  localparam logic [7:0] A_RATED_VOLT = 8'h18;
  localparam logic [7:0] A_FLOOR_VOLT = 8'h1c;
  localparam logic [7:0] A_VHZ_SLOPE = 8'h20;
  localparam logic [7:0] A_BOOST_SLOPE = 8'h24;
  localparam logic [7:0] A_PI_GAIN = 8'h28;
  localparam logic [7:0] A_CMD_FREQ = 8'h2c;
  localparam logic [7:0] A_CMD_VOLT = 8'h30;
  localparam logic [7:0] A_STATUS = 8'h34;
  localparam int NCFG = 11;
  localparam int NREG = 14;
  // Control fields
  localparam int C_EN = 0;
  localparam int C_EDGE = 1;
  localparam int C_PROF2 = 2;
  localparam int C_CLOSED = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values, indexed by word
  localparam logic [15:0] CFG_RST [0:NCFG-1] = '{16'h0000, 16'(PWM_HALF_CYC), 16'h0000, 16'h0400,
    16'h0040, 16'h0600, 16'h7000, 16'h1000, 16'h1c00, 16'h1999, 16'h1004};
  // One turn of sine, 16 steps
  localparam logic signed [7:0] SINE [0:15] = '{8'sh00, 8'sh31, 8'sh5a, 8'sh75, 8'sh7f, 8'sh75,
    8'sh5a, 8'sh31, 8'sh00, 8'shcf, 8'sha6, 8'sh8b, 8'sh81, 8'sh8b, 8'sha6, 8'shcf};
  localparam logic [23:0] PHASE_THIRD = 24'h555555;
  // Word index of a byte offset
  function automatic logic [3:0] ix(input logic [7:0] a);
    return a[5:2];
  endfunction
endpackage

// ---- hw/vhz_pwm_if.sv ----
`timescale 1ns/1ps
// Compare bus between the control core and the PWM timer
interface vhz_pwm_if;
  logic [15:0] top;
  logic edge_mode;
  logic [15:0] duty [3];
  logic load;
  logic [2:0] pat;
  modport gen (input top, input edge_mode, input duty, output load, output pat);
  modport ctl (output top, output edge_mode, output duty, input load, input pat);
endinterface

// ---- hw/vhz_pwm_gen.sv ----
`timescale 1ns/1ps
module vhz_pwm_gen
  import vhz_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  vhz_pwm_if.gen pw // Compare bus
);
  logic [15:0] cnt_r;
  logic down_r;
  logic edge_act_r;
  logic [15:0] top_act_r;
  logic [15:0] duty_act_r [3];

  // Period boundary: last count of a period, so new settings rule the whole next period from count zero
  assign pw.load = edge_act_r ? (cnt_r >= top_act_r) : (down_r && cnt_r == 16'h0001);

  // Up or up/down counter; settings latched only at the boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 16'h0000;
      down_r <= 1'b0;
      edge_act_r <= 1'b0;
      top_act_r <= 16'(PWM_HALF_CYC);
      duty_act_r <= '{3{16'h0000}};
    end else begin
      if (pw.load) begin
        duty_act_r <= pw.duty;
        top_act_r <= (pw.top < 16'h0002) ? 16'h0002 : pw.top;
        edge_act_r <= pw.edge_mode;
      end
      if (edge_act_r) begin
        cnt_r <= (cnt_r >= top_act_r) ? 16'h0000 : cnt_r + 16'h0001;
        down_r <= 1'b0;
      end else if (!down_r) begin
        cnt_r <= (cnt_r >= top_act_r) ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
        down_r <= (cnt_r >= top_act_r);
      end else begin
        cnt_r <= cnt_r - 16'h0001;
        down_r <= (cnt_r != 16'h0001);
      end
    end
  end

  // One comparator per phase
  for (genvar k = 0; k < 3; k++) begin : g_cmp
    assign pw.pat[k] = edge_act_r ? (cnt_r < duty_act_r[k])
      : ({1'b0, cnt_r} + {1'b0, duty_act_r[k]} > {1'b0, top_act_r});
  end

  property p_hold_duty;
    @(posedge aclk) disable iff (!aresetn) !pw.load |=> duty_act_r[0] == $past(duty_act_r[0]);
  endproperty
  a_hold_duty: assert property (p_hold_duty) else $error("duty changed inside a period");

  property p_edge_start;
    @(posedge aclk) disable iff (!aresetn)
      edge_act_r && cnt_r == 16'h0000 && duty_act_r[1] != 16'h0000 |-> pw.pat[1];
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("edge pulse not at period start");

  property p_sym_mid;
    @(posedge aclk) disable iff (!aresetn)
      !edge_act_r && cnt_r == top_act_r && duty_act_r[2] != 16'h0000 && duty_act_r[2] <= top_act_r
      |-> pw.pat[2] ##1 (pw.pat[2] == (duty_act_r[2] > 16'h0001));
  endproperty
  a_sym_mid: assert property (p_sym_mid) else $error("symmetric pulse not centred");

  property p_one_pulse;
    @(posedge aclk) disable iff (!aresetn)
      $rose(pw.pat[0]) && edge_act_r && $past(edge_act_r) |-> cnt_r == 16'h0000;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("extra pulse in period");
endmodule // vhz_pwm_gen

// ---- hw/vhz_ctrl.sv ----
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module vhz_ctrl
  import vhz_pkg::*;
#(
  parameter int SLIP_LIM = 1024,
  parameter int INTEG_LIM = 1048576
) (
  input wire logic aclk, // Clock, 10 MHz
  input wire logic aresetn, // Sync reset, low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [15:0] speed_meas, // Measured speed
  output logic [2:0] upper_sw, // Upper switch gates
  output logic [2:0] lower_sw // Lower switch gates
);
  logic [15:0] cfg_r [0:NCFG-1];
  logic [15:0] fcmd_r, vcmd_r;
  logic [23:0] phase_r;
  logic signed [31:0] integ_r, slip_r;
  logic below_r;
  logic [15:0] duty_r [3];
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [2:0] upper_r, lower_r;

  vhz_pwm_if pw ();

  vhz_pwm_gen u_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .pw(pw)
  );

  // Signed saturation to a symmetric limit
  function automatic logic signed [31:0] sat(input logic signed [31:0] x, input int lim);
    return (x > lim) ? 32'(lim) : (x < -lim) ? -32'(lim) : x;
  endfunction

  // Control fields
  wire en = cfg_r[ix(A_CTRL)][C_EN];
  wire prof2 = cfg_r[ix(A_CTRL)][C_PROF2];
  wire closed = cfg_r[ix(A_CTRL)][C_CLOSED];
  wire tick = pw.load;
  wire [15:0] f_rate = cfg_r[ix(A_RATED_FREQ)];
  wire [15:0] f_min = cfg_r[ix(A_FLOOR_FREQ)];
  wire [15:0] f_max = cfg_r[ix(A_MAX_FREQ)];
  wire [15:0] v_rate = cfg_r[ix(A_RATED_VOLT)];
  wire [15:0] v_min = cfg_r[ix(A_FLOOR_VOLT)];
  wire [15:0] set = cfg_r[ix(A_SPEED_SET)];
  wire [7:0] kp = cfg_r[ix(A_PI_GAIN)][15:8];
  wire [7:0] ki = cfg_r[ix(A_PI_GAIN)][7:0];

  // Speed loop: PI on speed error gives slip
  wire signed [31:0] err_w = $signed({16'h0000, set}) - $signed({16'h0000, speed_meas});
  wire signed [31:0] pterm_w = err_w * $signed({24'h000000, kp});
  wire signed [31:0] integ_nxt = sat(integ_r + err_w * $signed({24'h000000, ki}), INTEG_LIM);
  wire signed [31:0] slip_nxt = sat((pterm_w + integ_r) >>> 8, SLIP_LIM);
  wire signed [31:0] fsel_w = closed ? $signed({16'h0000, speed_meas}) + slip_nxt
    : $signed({16'h0000, set});
  wire [15:0] fsel = (fsel_w < 0) ? 16'h0000 : (fsel_w > 32'sh0000ffff) ? 16'hffff : fsel_w[15:0];

  // Frequency limits per profile
  wire [15:0] f_hi = (fsel > f_max) ? f_max : fsel;
  wire [15:0] feff = (!prof2 && f_hi < f_min) ? f_min : f_hi;

  // Voltage from frequency
  wire [31:0] vprop = ({16'h0000, feff} * {16'h0000, cfg_r[ix(A_VHZ_SLOPE)]}) >> 8;
  wire [31:0] v1 = (feff >= f_rate) ? {16'h0000, v_rate} : vprop;
  wire [15:0] fdel = (feff > f_min) ? feff - f_min : 16'h0000;
  wire [31:0] vlin = {16'h0000, v_min} + (({16'h0000, fdel} * {16'h0000, cfg_r[ix(A_BOOST_SLOPE)]}) >> 8);
  wire [31:0] v2 = (feff < f_min) ? {16'h0000, v_min} : vlin;
  wire [31:0] vraw = prof2 ? v2 : v1;
  wire [15:0] vnew = (vraw > {16'h0000, v_rate}) ? v_rate : vraw[15:0];

  // Compare values from phase and command voltage
  wire [15:0] half = pw.top >> 1;
  for (genvar k = 0; k < 3; k++) begin : g_duty
    wire [23:0] ph = phase_r + 24'(k) * PHASE_THIRD;
    wire signed [47:0] prod = $signed({16'h0000, half}) * $signed({16'h0000, vcmd_r}) * SINE[ph[23:20]];
    wire signed [47:0] off = prod >>> 23;
    wire [15:0] dnew = en ? 16'($signed({32'h00000000, half}) + off) : 16'h0000;
    assign pw.duty[k] = duty_r[k];
  end
  assign pw.top = cfg_r[ix(A_PERIOD)];
  assign pw.edge_mode = cfg_r[ix(A_CTRL)][C_EDGE];

  // Command values move only at the period boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcmd_r <= 16'h0000;
      vcmd_r <= 16'h0000;
      phase_r <= 24'h000000;
      integ_r <= 32'sh00000000;
      slip_r <= 32'sh00000000;
      below_r <= 1'b0;
      duty_r <= '{3{16'h0000}};
    end else if (tick) begin
      fcmd_r <= feff;
      vcmd_r <= vnew;
      phase_r <= phase_r + {8'h00, feff};
      integ_r <= closed ? integ_nxt : 32'sh00000000;
      slip_r <= closed ? slip_nxt : 32'sh00000000;
      below_r <= (fsel < f_min);
      duty_r <= '{g_duty[0].dnew, g_duty[1].dnew, g_duty[2].dnew};
    end
  end

  // Gate outputs: lower is always the inverse of upper
  wire [2:0] gate = en ? pw.pat : 3'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_r <= 3'h0;
      lower_r <= 3'h7;
    end else begin
      upper_r <= gate;
      lower_r <= ~gate;
    end
  end

  // Write channel decode
  wire aw_hs = s_axi_awvalid && awready_r;
  wire w_hs = s_axi_wvalid && wready_r;
  wire do_wr = aw_got_r && w_got_r && !bvalid_r;
  wire wr_ok = (awaddr_r[1:0] == 2'h0) && (awaddr_r[7:2] < 6'(NCFG));
  wire aw_got_nxt = do_wr ? 1'b0 : (aw_got_r || aw_hs);
  wire w_got_nxt = do_wr ? 1'b0 : (w_got_r || w_hs);
  wire bvalid_nxt = do_wr || (bvalid_r && !s_axi_bready);
  wire [15:0] wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      cfg_r <= CFG_RST;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= !aw_got_nxt && !bvalid_nxt;
      wready_r <= !w_got_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (aw_hs) awaddr_r <= s_axi_awaddr;
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_ok) cfg_r[awaddr_r[5:2]] <= (cfg_r[awaddr_r[5:2]] & ~wmask) | (wdata_r[15:0] & wmask);
      end
    end
  end

  // Read decode
  wire ar_hs = s_axi_arvalid && arready_r;
  wire [3:0] ridx = s_axi_araddr[5:2];
  wire rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[7:2] < 6'(NREG));
  wire [31:0] rd_mux = !rd_ok ? 32'h00000000
    : (ridx == ix(A_CMD_FREQ)) ? {16'h0000, fcmd_r}
    : (ridx == ix(A_CMD_VOLT)) ? {16'h0000, vcmd_r}
    : (ridx == ix(A_STATUS)) ? {slip_r[15:0], 12'h000, below_r, upper_r}
    : {16'h0000, cfg_r[ridx]};
  wire rvalid_nxt = ar_hs || (rvalid_r && !s_axi_rready);

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Ports from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign upper_sw = upper_r;
  assign lower_sw = lower_r;

  property p_compl;
    @(posedge aclk) disable iff (!aresetn) lower_sw == ~upper_sw;
  endproperty
  a_compl: assert property (p_compl) else $error("lower not inverse of upper");

  property p_vclamp;
    @(posedge aclk) disable iff (!aresetn) tick |=> vcmd_r <= $past(v_rate);
  endproperty
  a_vclamp: assert property (p_vclamp) else $error("command voltage above rated");

  property p_floor;
    @(posedge aclk) disable iff (!aresetn) tick && !prof2 && f_min <= f_max |=> fcmd_r >= $past(f_min);
  endproperty
  a_floor: assert property (p_floor) else $error("frequency below floor");

  property p_prof2_low;
    @(posedge aclk) disable iff (!aresetn)
      tick && prof2 && fsel < f_min && v_min <= v_rate |=> vcmd_r == $past(v_min);
  endproperty
  a_prof2_low: assert property (p_prof2_low) else $error("floor voltage not held");

  property p_rated;
    @(posedge aclk) disable iff (!aresetn) tick && !prof2 && feff >= f_rate |=> vcmd_r == $past(v_rate);
  endproperty
  a_rated: assert property (p_rated) else $error("rated voltage not applied");

  property p_open;
    @(posedge aclk) disable iff (!aresetn)
      tick && !closed && set >= f_min && set <= f_max |=> fcmd_r == $past(set);
  endproperty
  a_open: assert property (p_open) else $error("open loop frequency not set speed");

  property p_pi;
    @(posedge aclk) disable iff (!aresetn)
      tick && closed && err_w > 0 && ki != 8'h00 && integ_r < INTEG_LIM |=> integ_r > $past(integ_r);
  endproperty
  a_pi: assert property (p_pi) else $error("integrator not following error");

  property p_sync;
    @(posedge aclk) disable iff (!aresetn) !tick |=> $stable(vcmd_r) && $stable(fcmd_r) ##0 $stable(duty_r[0]);
  endproperty
  a_sync: assert property (p_sync) else $error("command changed inside a period");
endmodule // vhz_ctrl

// ---- dv/vhz_gate_model.sv ----
`timescale 1ns/1ps
// Gate drive stand-in: counts cycles where a leg is not complementary
module vhz_gate_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [2:0] upper_sw, // Upper gates
  input wire logic [2:0] lower_sw, // Lower gates
  output logic [15:0] leg_faults // Bad leg cycles
);
  // A leg with both or neither switch on would short or float the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      leg_faults <= 16'h0000;
    end else if (lower_sw !== ~upper_sw) begin
      leg_faults <= leg_faults + 16'h0001;
    end
  end
endmodule // vhz_gate_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  import vhz_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, d, v, old;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] speed_meas, leg_faults;
  logic [15:0] sp [8];
  logic [2:0] upper_sw, lower_sw;
  logic [2:0] cap [0:99];
  int miscompares, num_checks, cyc;

  vhz_ctrl u_vhz_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .speed_meas(speed_meas),
    .upper_sw(upper_sw), .lower_sw(lower_sw));
  vhz_gate_model u_vhz_gate_model (.aclk(aclk), .aresetn(aresetn), .upper_sw(upper_sw), .lower_sw(lower_sw),
    .leg_faults(leg_faults));

  // Clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Profile one frequency limits at reset settings
  function automatic logic [31:0] clampf(input logic [15:0] s);
    if (s < 16'h0040) return 32'h0000_0040;
    if (s > 16'h0600) return 32'h0000_0600;
    return {16'h0000, s};
  endfunction
  // Profile one voltage with no boost
  function automatic logic [31:0] exp_v1(input logic [15:0] f);
    if (f >= 16'h0400) return 32'h0000_7000;
    return ({16'h0000, f} * 32'h0000_1c00) >> 8;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      close_out();
    end
  end

  // Bus write: both channels offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s, output logic [1:0] r);
    awaddr <= a;
    wdata <= dt;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        dt = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask

  task automatic w(input logic [7:0] a, input logic [15:0] dt);
    logic [1:0] r;
    wr(a, {16'h0000, dt}, 4'h3, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] dt;
    logic [1:0] r;
    rd_reg(a, dt, r);
    chk(dt, exp);
  endtask

  // Capture gates from an all-off point and compare pulse placement across phases
  task automatic pwm_chk(input bit edge_m, input int t);
    int r [3];
    int f [3];
    int r2 [3];
    int ref_k;
    int n;
    bit prev;
    n = 0;
    ref_k = -1;
    while (upper_sw !== 3'h0 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      cap[i] = upper_sw;
    end
    for (int k = 0; k < 3; k++) begin
      r[k] = -1;
      f[k] = -1;
      r2[k] = -1;
      // The sample just before cap[0] was all off, so an edge at index 0 counts
      prev = 1'b0;
      for (int i = 0; i < 100; i++) begin
        if (cap[i][k] && !prev) begin
          if (r[k] < 0) r[k] = i;
          else if (r2[k] < 0) r2[k] = i;
        end
        if (!cap[i][k] && prev && r[k] >= 0 && f[k] < 0) f[k] = i;
        prev = cap[i][k];
      end
      if (r[k] >= 0 && f[k] >= 0) begin
        if (ref_k < 0) ref_k = k;
        else if (edge_m) chk(32'(r[k]), 32'(r[ref_k]));
        else chk(32'(r[k] + f[k]), 32'(r[ref_k] + f[ref_k]));
        if (r2[k] >= 0) chk(32'(r2[k] - r[k]), edge_m ? 32'(t + 1) : 32'(2 * t));
      end
    end
    chk(32'(ref_k >= 0), 32'h1);
  endtask

  // Main sequence
  initial begin
    seed = 32'h3f7b4870;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    speed_meas = 16'h0000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(upper_sw), 32'h0);
    chk(32'(lower_sw), 32'h7);
    for (int i = 0; i < NCFG; i++) rchk(8'(4 * i), {16'h0000, CFG_RST[i]});
    rd_reg(8'h38, d, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    rd_reg(8'h02, d, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(A_CMD_FREQ, 32'h0000_1234, 4'hf, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    // Byte strobes merge into the stored word
    old = {16'h0000, CFG_RST[2]};
    for (int i = 0; i < 4; i++) begin
      v = xs();
      wr(A_SPEED_SET, v, {2'b00, v[17:16]}, rs);
      old = {16'h0000, v[17] ? v[15:8] : old[15:8], v[16] ? v[7:0] : old[7:0]};
      rchk(A_SPEED_SET, old);
    end
    rd_reg(A_STATUS, d, rs);
    chk(32'(d[2:0]), 32'h0);
    // Profile one, open loop, no boost
    w(A_PERIOD, 16'h0014);
    w(A_BOOST_SLOPE, 16'h0000);
    w(A_CTRL, 16'h0001);
    // Let the long reset period run out so the short period and new commands are in force
    repeat (1000) @(posedge aclk);
    sp = '{16'h0010, 16'h0040, 16'h0200, 16'h0400, 16'h0500, 16'h0700, 16'h0000, 16'h0000};
    v = xs();
    sp[6] = v[15:0];
    sp[7] = v[31:16];
    foreach (sp[i]) begin
      v = xs();
      speed_meas <= v[15:0];
      w(A_SPEED_SET, sp[i]);
      repeat (300) @(posedge aclk);
      rchk(A_CMD_FREQ, clampf(sp[i]));
      rchk(A_CMD_VOLT, exp_v1(16'(clampf(sp[i]))));
    end
    // Low frequency boost belongs to profile two
    w(A_CTRL, 16'h0005);
    w(A_BOOST_SLOPE, 16'h1999);
    w(A_SPEED_SET, 16'h0040);
    repeat (300) @(posedge aclk);
    rd_reg(A_CMD_VOLT, d, rs);
    chk(32'(d > 32'h0000_0700), 32'h1);
    // Pulse placement in both modes
    w(A_SPEED_SET, 16'h0200);
    repeat (300) @(posedge aclk);
    pwm_chk(1'b0, 20);
    w(A_CTRL, 16'h0003);
    repeat (300) @(posedge aclk);
    pwm_chk(1'b1, 20);
    // Profile two
    w(A_CTRL, 16'h0005);
    w(A_SPEED_SET, 16'h0020);
    repeat (300) @(posedge aclk);
    rchk(A_CMD_FREQ, 32'h0000_0020);
    rchk(A_CMD_VOLT, 32'h0000_1000);
    w(A_SPEED_SET, 16'h0220);
    repeat (300) @(posedge aclk);
    rchk(A_CMD_VOLT, 32'h0000_1000 + ((32'h0000_01e0 * 32'h0000_1999) >> 8));
    w(A_SPEED_SET, 16'h0500);
    repeat (300) @(posedge aclk);
    rchk(A_CMD_VOLT, 32'h0000_7000);
    // Closed loop drives slip to its limit in both directions
    speed_meas <= 16'h0100;
    w(A_CTRL, 16'h0009);
    w(A_SPEED_SET, 16'h0300);
    repeat (10000) @(posedge aclk);
    rchk(A_CMD_FREQ, 32'h0000_0500);
    speed_meas <= 16'h0600;
    repeat (20000) @(posedge aclk);
    rchk(A_CMD_FREQ, 32'h0000_0200);
    // Disable parks the bridge
    w(A_CTRL, 16'h0000);
    repeat (300) @(posedge aclk);
    chk(32'(upper_sw), 32'h0);
    chk(32'(lower_sw), 32'h7);
    chk(32'(leg_faults), 32'h0);
    close_out();
  end
endmodule // tb
